// ---- buere_top.sv ----
`timescale 1ns/1ns
`default_nettype none

// How it works
// (RULE_01) Exception needs global and local enable
// (RULE_02) Local off: log error, no exception
// (RULE_03) Global off: neither log nor exception
// (RULE_04) Bits 19,18: tag scrub ECC enables
// (RULE_05) Bits 17..15: data multi-bit ECC enables
// (RULE_06) Bits 14..12: data single-bit ECC enables
// (RULE_07) Bits 11..7: tag parity enables
// (RULE_08) Bits 6..3: system data ECC enables
// (RULE_09) Bits 0,1: read errors prefetch, reload
// (RULE_10) Bit 2: read errors any operation
// (RULE_11) 64-bit register, 20 enables reset zero
// (RULE_12) Catch-all covers fetch, reload, prefetch
// (RULE_13) Instruction cache read enable needs bit 2
// (RULE_14) Mask bits block writing ones
// (RULE_15) Reserved bits read zero, writes ignored

module buere_top
(
  input  wire logic                   CLOCK,
  input  wire logic                   RESET,
  input  wire logic                   MSR_WR_EN,
  input  wire logic                   MSR_RD_EN,
  input  wire logic [31:0]            MSR_INDEX,
  input  wire logic [63:0]            MSR_WDATA,
  output var  logic [63:0]            MSR_RDATA,
  output var  logic                   MSR_RD_HIT,
  input  wire logic [19:0]            BUS_UNIT_ENABLE_WRITE_MASK,
  input  wire logic                   GLOBAL_BUS_UNIT_ENABLE,
  input  wire logic                   ERR_VALID,
  input  wire buere_pkg::buere_kind_type ERR_KIND,
  input  wire buere_pkg::buere_op_type   ERR_OP,
  input  wire logic                   ICACHE_READERR_EN,
  input  wire logic                   ICACHE_READERR_VALID,
  output var  logic                   LOG_STROBE,
  output var  buere_pkg::buere_kind_type LOG_KIND,
  output var  buere_pkg::buere_op_type   LOG_OP,
  output var  logic                   MCE_REQUEST,
  output var  logic                   ICACHE_READERR_REPORT
);

  // ------------------------------------------------------------
  // Local signals
  // ------------------------------------------------------------
  buere_reg_if regs ();          // Link to enable storage
  logic        index_hit;        // Access targets this register
  logic        local_enable;     // Selected local enable of event
  logic        log_nxt;          // Event is to be logged
  logic        mce_nxt;          // Event raises exception
  logic        ic_report_nxt;    // Instruction cache read error report
  logic [63:0] rdata_nxt;        // Read value

  // ------------------------------------------------------------
  // Enable storage
  // ------------------------------------------------------------
  // Twenty local enables, cleared by reset
  buere_enable_reg u_store
  (
    .clock (CLOCK),
    .reset (RESET),
    .regs  (regs.store)
  );

  // ------------------------------------------------------------
  // Register access decode
  // ------------------------------------------------------------

  // Index compare for both reads and writes
  assign index_hit = (MSR_INDEX == buere_pkg::CHECK_ENABLE_INDEX);

  // Write path: only low enables stored, upper bits dropped
  always_comb
  begin
    // Strobe only for this register's index
    regs.wr_en   = MSR_WR_EN & index_hit;
    // Reserved upper bits never reach storage
    regs.wr_data = MSR_WDATA[19:0]; // RULE_15
    // Mask applied inside the store
    regs.wr_mask = BUS_UNIT_ENABLE_WRITE_MASK; // RULE_14
  end

  // Read value: reserved bits forced to zero
  always_comb
  begin
    // Upper 44 bits are reserved
    rdata_nxt = {buere_pkg::RESERVED_VALUE, regs.enables}; // RULE_15
  end

  // Registered read data, zero when not hit
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      // Read port idle after reset
      MSR_RDATA  <= 64'h0000_0000_0000_0000;
      MSR_RD_HIT <= 1'b0;
    end
    else
    begin
      // Hit flag stands for one cycle
      MSR_RD_HIT <= MSR_RD_EN & index_hit;
      if (MSR_RD_EN & index_hit)
      begin
        // Present the stored enables
        MSR_RDATA <= rdata_nxt; // RULE_11
      end
      else
      begin
        // Idle or foreign index reads zero
        MSR_RDATA <= 64'h0000_0000_0000_0000;
      end
    end
  end

  // ------------------------------------------------------------
  // Local enable selection per category and operation
  // ------------------------------------------------------------
  always_comb
  begin
    // Nothing enabled unless a branch says so
    local_enable = 1'b0;
    case (ERR_KIND)
      // System read data: catch-all or per operation
      buere_pkg::KIND_SYS_READERR:
      begin
        local_enable = regs.enables[buere_pkg::SYS_READERR_ANY_EN]; // RULE_10 RULE_12
        if (ERR_OP == buere_pkg::OP_PREFETCH)
        begin
          // Prefetch has its own enable as well
          local_enable = local_enable | regs.enables[buere_pkg::SYS_READERR_PREFETCH_EN]; // RULE_09
        end
        else if (ERR_OP == buere_pkg::OP_TLBRELOAD)
        begin
          // Table walk reload has its own enable as well
          local_enable = local_enable | regs.enables[buere_pkg::SYS_READERR_TLBRELOAD_EN]; // RULE_09
        end
      end
      // System data multi-bit ECC
      buere_pkg::KIND_SYS_MULTIBIT:
      begin
        if (ERR_OP == buere_pkg::OP_PREFETCH)
        begin
          // Multi-bit error on a prefetch
          local_enable = regs.enables[buere_pkg::SYS_MULTIBIT_PREFETCH_EN]; // RULE_08
        end
        else if (ERR_OP == buere_pkg::OP_TLBRELOAD)
        begin
          // Multi-bit error on a table walk reload
          local_enable = regs.enables[buere_pkg::SYS_MULTIBIT_TLBRELOAD_EN]; // RULE_08
        end
      end
      // System data single-bit ECC
      buere_pkg::KIND_SYS_SINGLEBIT:
      begin
        if (ERR_OP == buere_pkg::OP_PREFETCH)
        begin
          // Single-bit error on a prefetch
          local_enable = regs.enables[buere_pkg::SYS_SINGLEBIT_PREFETCH_EN]; // RULE_08
        end
        else if (ERR_OP == buere_pkg::OP_TLBRELOAD)
        begin
          // Single-bit error on a table walk reload
          local_enable = regs.enables[buere_pkg::SYS_SINGLEBIT_TLBRELOAD_EN]; // RULE_08
        end
      end
      // L2 tag parity by operation
      buere_pkg::KIND_TAG_PARITY:
      begin
        // One enable per operation, none for prefetch
        case (ERR_OP)
          buere_pkg::OP_SCRUB:     local_enable = regs.enables[buere_pkg::TAG_PARITY_SCRUB_EN];     // RULE_07
          buere_pkg::OP_COPYBACK:  local_enable = regs.enables[buere_pkg::TAG_PARITY_COPYBACK_EN];  // RULE_07
          buere_pkg::OP_SNOOP:     local_enable = regs.enables[buere_pkg::TAG_PARITY_SNOOP_EN];     // RULE_07
          buere_pkg::OP_TLBRELOAD: local_enable = regs.enables[buere_pkg::TAG_PARITY_TLBRELOAD_EN]; // RULE_07
          buere_pkg::OP_FETCH:     local_enable = regs.enables[buere_pkg::TAG_PARITY_FETCH_EN];     // RULE_07
          default:                 local_enable = 1'b0;
        endcase
      end
      // L2 data multi-bit ECC by operation
      buere_pkg::KIND_DATA_MULTIBIT:
      begin
        // No enable for fetch, scrub or prefetch
        case (ERR_OP)
          buere_pkg::OP_COPYBACK:  local_enable = regs.enables[buere_pkg::DATA_MULTIBIT_COPYBACK_EN];  // RULE_05
          buere_pkg::OP_SNOOP:     local_enable = regs.enables[buere_pkg::DATA_MULTIBIT_SNOOP_EN];     // RULE_05
          buere_pkg::OP_TLBRELOAD: local_enable = regs.enables[buere_pkg::DATA_MULTIBIT_TLBRELOAD_EN]; // RULE_05
          default:                 local_enable = 1'b0;
        endcase
      end
      // L2 data single-bit ECC by operation
      buere_pkg::KIND_DATA_SINGLEBIT:
      begin
        // No enable for fetch, scrub or prefetch
        case (ERR_OP)
          buere_pkg::OP_COPYBACK:  local_enable = regs.enables[buere_pkg::DATA_SINGLEBIT_COPYBACK_EN];  // RULE_06
          buere_pkg::OP_SNOOP:     local_enable = regs.enables[buere_pkg::DATA_SINGLEBIT_SNOOP_EN];     // RULE_06
          buere_pkg::OP_TLBRELOAD: local_enable = regs.enables[buere_pkg::DATA_SINGLEBIT_TLBRELOAD_EN]; // RULE_06
          default:                 local_enable = 1'b0;
        endcase
      end
      // L2 tag ECC, scrub only
      buere_pkg::KIND_TAG_MULTIBIT:
      begin
        if (ERR_OP == buere_pkg::OP_SCRUB)
        begin
          // Multi-bit tag error found by a scrub
          local_enable = regs.enables[buere_pkg::TAG_MULTIBIT_SCRUB_EN]; // RULE_04
        end
      end
      // Single-bit tag ECC, scrub only
      buere_pkg::KIND_TAG_SINGLEBIT:
      begin
        if (ERR_OP == buere_pkg::OP_SCRUB)
        begin
          // Single-bit tag error found by a scrub
          local_enable = regs.enables[buere_pkg::TAG_SINGLEBIT_SCRUB_EN]; // RULE_04
        end
      end
      // Unknown category never raises an exception
      default:
      begin
        local_enable = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Gating against the global unit enable
  // ------------------------------------------------------------
  always_comb
  begin
    // Logged whenever the unit is globally enabled
    log_nxt = ERR_VALID & GLOBAL_BUS_UNIT_ENABLE; // RULE_02 RULE_03
    // Exception needs the local enable on top
    mce_nxt = log_nxt & local_enable; // RULE_01
    // Instruction cache read errors lean on the catch-all bit
    ic_report_nxt = ICACHE_READERR_VALID & ICACHE_READERR_EN
                  & regs.enables[buere_pkg::SYS_READERR_ANY_EN]; // RULE_13
  end

  // ------------------------------------------------------------
  // Registered event outputs
  // ------------------------------------------------------------

  // Log strobe with captured category and operation
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      // No pending log after reset
      LOG_STROBE <= 1'b0;
      LOG_KIND   <= buere_pkg::KIND_SYS_READERR;
      LOG_OP     <= buere_pkg::OP_FETCH;
    end
    else
    begin
      // Strobe stands one cycle per event
      LOG_STROBE <= log_nxt; // RULE_02 RULE_03
      if (log_nxt)
      begin
        // Fields hold until the next logged event
        LOG_KIND <= ERR_KIND;
        LOG_OP   <= ERR_OP;
      end
    end
  end

  // Machine check request pulse
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      // No exception pending after reset
      MCE_REQUEST <= 1'b0;
    end
    else
    begin
      // One pulse per enabled event
      MCE_REQUEST <= mce_nxt; // RULE_01
    end
  end

  // Instruction cache read error report pulse
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      // No report pending after reset
      ICACHE_READERR_REPORT <= 1'b0;
    end
    else
    begin
      // One pulse per gated event
      ICACHE_READERR_REPORT <= ic_report_nxt; // RULE_13
    end
  end

endmodule

`default_nettype wire

// ---- buere_pkg.sv ----
`default_nettype none

package buere_pkg;

  // ------------------------------------------------------------
  // Register access
  // ------------------------------------------------------------
  localparam logic [31:0] CHECK_ENABLE_INDEX = 32'h0000_0408; // Model-specific index
  localparam int          REG_WIDTH          = 64;            // Full register width
  localparam int          ENABLE_COUNT       = 20;            // Implemented enable bits
  localparam logic [19:0] ENABLE_RESET       = 20'h0_0000;    // Enable reset value
  localparam logic [43:0] RESERVED_VALUE     = 44'h000_0000_0000; // Bits 63..20

  // ------------------------------------------------------------
  // Enable bit positions
  // ------------------------------------------------------------
  localparam int SYS_READERR_PREFETCH_EN    = 0;
  localparam int SYS_READERR_TLBRELOAD_EN   = 1;
  localparam int SYS_READERR_ANY_EN         = 2;
  localparam int SYS_SINGLEBIT_TLBRELOAD_EN = 3;
  localparam int SYS_SINGLEBIT_PREFETCH_EN  = 4;
  localparam int SYS_MULTIBIT_TLBRELOAD_EN  = 5;
  localparam int SYS_MULTIBIT_PREFETCH_EN   = 6;
  localparam int TAG_PARITY_FETCH_EN        = 7;
  localparam int TAG_PARITY_TLBRELOAD_EN    = 8;
  localparam int TAG_PARITY_SNOOP_EN        = 9;
  localparam int TAG_PARITY_COPYBACK_EN     = 10;
  localparam int TAG_PARITY_SCRUB_EN        = 11;
  localparam int DATA_SINGLEBIT_TLBRELOAD_EN = 12;
  localparam int DATA_SINGLEBIT_SNOOP_EN    = 13;
  localparam int DATA_SINGLEBIT_COPYBACK_EN = 14;
  localparam int DATA_MULTIBIT_TLBRELOAD_EN = 15;
  localparam int DATA_MULTIBIT_SNOOP_EN     = 16;
  localparam int DATA_MULTIBIT_COPYBACK_EN  = 17;
  localparam int TAG_SINGLEBIT_SCRUB_EN     = 18;
  localparam int TAG_MULTIBIT_SCRUB_EN      = 19;

  // ------------------------------------------------------------
  // Error categories reported by the bus interface unit
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    KIND_SYS_READERR   = 3'h0, // System read data error
    KIND_SYS_MULTIBIT  = 3'h1, // System data multi-bit ECC
    KIND_SYS_SINGLEBIT = 3'h2, // System data single-bit ECC
    KIND_TAG_PARITY    = 3'h3, // L2 tag parity
    KIND_DATA_MULTIBIT = 3'h4, // L2 data multi-bit ECC
    KIND_DATA_SINGLEBIT = 3'h5, // L2 data single-bit ECC
    KIND_TAG_MULTIBIT  = 3'h6, // L2 tag multi-bit ECC
    KIND_TAG_SINGLEBIT = 3'h7  // L2 tag single-bit ECC
  } buere_kind_type;

  // ------------------------------------------------------------
  // Operation that met the error
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_FETCH     = 3'h0, // Instruction or data cache fetch
    OP_TLBRELOAD = 3'h1, // Table walk reload
    OP_SNOOP     = 3'h2, // Snoop
    OP_COPYBACK  = 3'h3, // Copyback
    OP_SCRUB     = 3'h4, // Scrub
    OP_PREFETCH  = 3'h5  // Hardware prefetch
  } buere_op_type;

endpackage

`default_nettype wire

// ---- buere_reg_if.sv ----
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// Link between access decode and enable storage
// ------------------------------------------------------------
interface buere_reg_if;
  logic        wr_en;   // One-cycle write strobe
  logic [19:0] wr_data; // Written enable value
  logic [19:0] wr_mask; // Set bits block writing ones
  logic [19:0] enables; // Stored enables

  modport ctrl (output wr_en, output wr_data, output wr_mask, input enables);
  modport store (input wr_en, input wr_data, input wr_mask, output enables);
endinterface

`default_nettype wire

// ---- buere_enable_reg.sv ----
`timescale 1ns/1ns
`default_nettype none

module buere_enable_reg
(
  input  wire logic  clock,
  input  wire logic  reset,
  buere_reg_if.store regs
);

  // ------------------------------------------------------------
  // Enable storage
  // ------------------------------------------------------------
  logic [19:0] enables_r;   // Stored local enables
  logic [19:0] enables_nxt; // Value after a write

  // Masked bits may be cleared but never set by a write
  always_comb
  begin
    enables_nxt = regs.wr_data & ~regs.wr_mask; // RULE_14
  end

  // Reset to zero, load on write strobe
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      enables_r <= buere_pkg::ENABLE_RESET; // RULE_11
    end
    else if (regs.wr_en)
    begin
      enables_r <= enables_nxt; // RULE_11
    end
  end

  assign regs.enables = enables_r;

endmodule

`default_nettype wire

// ---- buere_properties.sv ----
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// Port checker for the bus unit enable block
// ------------------------------------------------------------
module buere_properties
(
  input wire logic                      CLOCK,
  input wire logic                      RESET,
  input wire logic                      MSR_RD_EN,
  input wire logic [31:0]               MSR_INDEX,
  input wire logic [63:0]               MSR_RDATA,
  input wire logic                      MSR_RD_HIT,
  input wire logic                      GLOBAL_BUS_UNIT_ENABLE,
  input wire logic                      ERR_VALID,
  input wire buere_pkg::buere_kind_type ERR_KIND,
  input wire buere_pkg::buere_op_type   ERR_OP,
  input wire logic                      ICACHE_READERR_EN,
  input wire logic                      ICACHE_READERR_VALID,
  input wire logic                      LOG_STROBE,
  input wire buere_pkg::buere_kind_type LOG_KIND,
  input wire buere_pkg::buere_op_type   LOG_OP,
  input wire logic                      MCE_REQUEST,
  input wire logic                      ICACHE_READERR_REPORT
);
  // Single clock domain, checks off during reset
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  // Disabled unit neither logs nor raises
  property p_global_off;
    ERR_VALID && !GLOBAL_BUS_UNIT_ENABLE |=> !LOG_STROBE && !MCE_REQUEST;
  endproperty
  a_global_off: assert property (p_global_off) else $error("event reported while unit disabled");

  // Enabled unit always logs, with the event fields
  property p_log_fields;
    ERR_VALID && GLOBAL_BUS_UNIT_ENABLE |=> LOG_STROBE && LOG_KIND == $past(ERR_KIND) && LOG_OP == $past(ERR_OP);
  endproperty
  a_log_fields: assert property (p_log_fields) else $error("event not logged correctly");

  // Exception never without a log
  property p_mce_logged;
    MCE_REQUEST |-> LOG_STROBE;
  endproperty
  a_mce_logged: assert property (p_mce_logged) else $error("exception without log");

  // No event, no strobe
  property p_no_event;
    !ERR_VALID |=> !LOG_STROBE && !MCE_REQUEST;
  endproperty
  a_no_event: assert property (p_no_event) else $error("strobe without event");

  // Tag ECC enables exist for scrubs only
  property p_tag_ecc_scrub;
    ERR_VALID && ERR_KIND inside {buere_pkg::KIND_TAG_MULTIBIT, buere_pkg::KIND_TAG_SINGLEBIT}
      && ERR_OP != buere_pkg::OP_SCRUB |=> !MCE_REQUEST;
  endproperty
  a_tag_ecc_scrub: assert property (p_tag_ecc_scrub) else $error("tag ECC raised outside scrub");

  // Read of own index answers next cycle
  property p_rd_hit;
    MSR_RD_EN && MSR_INDEX == 32'h0000_0408 |=> MSR_RD_HIT;
  endproperty
  a_rd_hit: assert property (p_rd_hit) else $error("read not answered");

  // Other cycles return nothing
  property p_rd_miss;
    !(MSR_RD_EN && MSR_INDEX == 32'h0000_0408) |=> !MSR_RD_HIT && MSR_RDATA == 64'h0;
  endproperty
  a_rd_miss: assert property (p_rd_miss) else $error("read data outside hit");

  // Reserved bits always zero
  property p_reserved;
    MSR_RDATA[63:20] == 44'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved read bits set");

  // Icache report needs its event and enable
  property p_icache;
    ICACHE_READERR_REPORT |-> $past(ICACHE_READERR_VALID) && $past(ICACHE_READERR_EN);
  endproperty
  a_icache: assert property (p_icache) else $error("icache report without cause");
endmodule

`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ns
`default_nettype none

module tb;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam logic [31:0]    IDX = buere_pkg::CHECK_ENABLE_INDEX; // Own index
  logic                      CLOCK, RESET, MSR_WR_EN, MSR_RD_EN, GLOBAL_BUS_UNIT_ENABLE, ERR_VALID;
  logic                      ICACHE_READERR_EN, ICACHE_READERR_VALID, MSR_RD_HIT, LOG_STROBE, MCE_REQUEST;
  logic                      ICACHE_READERR_REPORT;
  logic [31:0]               MSR_INDEX;
  logic [63:0]               MSR_WDATA, MSR_RDATA, wd;
  logic [19:0]               BUS_UNIT_ENABLE_WRITE_MASK;
  buere_pkg::buere_kind_type ERR_KIND, LOG_KIND;
  buere_pkg::buere_op_type   ERR_OP, LOG_OP;
  logic [19:0]               model_en;     // Reference enables
  logic [31:0]               rng_r;        // Random state
  int                        miscompares, samples_checked;

  buere_top buere_top_i
  (
    .CLOCK                      (CLOCK),
    .RESET                      (RESET),
    .MSR_WR_EN                  (MSR_WR_EN),
    .MSR_RD_EN                  (MSR_RD_EN),
    .MSR_INDEX                  (MSR_INDEX),
    .MSR_WDATA                  (MSR_WDATA),
    .MSR_RDATA                  (MSR_RDATA),
    .MSR_RD_HIT                 (MSR_RD_HIT),
    .BUS_UNIT_ENABLE_WRITE_MASK (BUS_UNIT_ENABLE_WRITE_MASK),
    .GLOBAL_BUS_UNIT_ENABLE     (GLOBAL_BUS_UNIT_ENABLE),
    .ERR_VALID                  (ERR_VALID),
    .ERR_KIND                   (ERR_KIND),
    .ERR_OP                     (ERR_OP),
    .ICACHE_READERR_EN          (ICACHE_READERR_EN),
    .ICACHE_READERR_VALID       (ICACHE_READERR_VALID),
    .LOG_STROBE                 (LOG_STROBE),
    .LOG_KIND                   (LOG_KIND),
    .LOG_OP                     (LOG_OP),
    .MCE_REQUEST                (MCE_REQUEST),
    .ICACHE_READERR_REPORT      (ICACHE_READERR_REPORT)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Xorshift source
  function automatic logic [31:0] rnd();
    rng_r = rng_r ^ (rng_r << 13);
    rng_r = rng_r ^ (rng_r >> 17);
    rng_r = rng_r ^ (rng_r << 5);
    return rng_r;
  endfunction

  // Expected exception for kind, op and enables
  function automatic logic exp_mce(input logic [19:0] e, input int k, input int o);
    case (k)
      0: return e[2] | (o == 5 && e[0]) | (o == 1 && e[1]);
      1: return (o == 5 && e[6]) | (o == 1 && e[5]);
      2: return (o == 5 && e[4]) | (o == 1 && e[3]);
      3: return (o == 4 && e[11]) | (o == 3 && e[10]) | (o == 2 && e[9])
              | (o == 1 && e[8]) | (o == 0 && e[7]);
      4: return (o == 3 && e[17]) | (o == 2 && e[16]) | (o == 1 && e[15]);
      5: return (o == 3 && e[14]) | (o == 2 && e[13]) | (o == 1 && e[12]);
      6: return o == 4 && e[19];
      default: return o == 4 && e[18];
    endcase
  endfunction

  // Compare and count
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Register write, entered at a falling edge
  task automatic wr(input logic [31:0] idx, input logic [63:0] d, input logic [19:0] m);
    MSR_WR_EN = 1'h1;
    MSR_INDEX = idx;
    MSR_WDATA = d;
    BUS_UNIT_ENABLE_WRITE_MASK = m;
    @(negedge CLOCK);
    MSR_WR_EN = 1'h0;
    if (idx == IDX)
      model_en = d[19:0] & ~m;
  endtask

  // Register read with check
  task automatic rd(input logic [31:0] idx);
    MSR_RD_EN = 1'h1;
    MSR_INDEX = idx;
    @(negedge CLOCK);
    MSR_RD_EN = 1'h0;
    chk("read hit", MSR_RD_HIT, idx == IDX);
    chk("read data", MSR_RDATA, (idx == IDX) ? {44'h0, model_en} : 64'h0);
    // Idle edge keeps back-to-back strobes apart
    @(negedge CLOCK);
  endtask

  // Error event with check
  task automatic ev(input int k, input int o, input logic g);
    ERR_VALID = 1'h1;
    ERR_KIND = buere_pkg::buere_kind_type'(k[2:0]);
    ERR_OP = buere_pkg::buere_op_type'(o[2:0]);
    GLOBAL_BUS_UNIT_ENABLE = g;
    @(negedge CLOCK);
    ERR_VALID = 1'h0;
    chk("log strobe", LOG_STROBE, g);
    chk("exception", MCE_REQUEST, g & exp_mce(model_en, k, o));
    if (g)
      chk("log fields", {LOG_KIND, LOG_OP}, {k[2:0], o[2:0]});
    // Idle edge keeps back-to-back strobes apart
    @(negedge CLOCK);
  endtask

  // Icache read error event with check
  task automatic ic(input logic v, input logic e);
    ICACHE_READERR_VALID = v;
    ICACHE_READERR_EN = e;
    @(negedge CLOCK);
    ICACHE_READERR_VALID = 1'h0;
    chk("icache report", ICACHE_READERR_REPORT, v & e & model_en[2]);
    // Idle edge keeps back-to-back strobes apart
    @(negedge CLOCK);
  endtask

  // Verdict and stop
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Clock, watchdog, sequence
  // ------------------------------------------------------------
  initial
  begin
    CLOCK = 1'h0;
    forever #5 CLOCK = ~CLOCK;
  end

  // Cuts a hang short
  initial
  begin
    #200000;
    miscompares++;
    end_sim();
  end

  initial
  begin
    {RESET, MSR_WR_EN, MSR_RD_EN, GLOBAL_BUS_UNIT_ENABLE, ERR_VALID, ICACHE_READERR_EN} = 6'h20;
    ICACHE_READERR_VALID = 1'h0;
    MSR_INDEX = 32'h0;
    MSR_WDATA = 64'h0;
    BUS_UNIT_ENABLE_WRITE_MASK = 20'h0;
    ERR_KIND = buere_pkg::KIND_SYS_READERR;
    ERR_OP = buere_pkg::OP_FETCH;
    model_en = 20'h0;
    rng_r = 32'hF7DF1D02;
    miscompares = 0;
    samples_checked = 0;
    repeat (5) @(negedge CLOCK);
    RESET = 1'h0;
    rd(IDX);
    wr(IDX, 64'hFFFF_FFFF_FFFF_FFFF, 20'h0_0001);
    rd(IDX);
    wr(32'h0000_0409, 64'h0, 20'h0);
    rd(32'h0000_0409);
    rd(IDX);
    // One enable at a time across every kind and operation
    for (int b = 0; b < 20; b++)
    begin
      wr(IDX, 64'h1 << b, 20'h0);
      for (int k = 0; k < 8; k++)
        for (int o = 0; o < 6; o++)
          ev(k, o, 1'h1);
    end
    // Icache gating on and off the catch-all bit
    wr(IDX, 64'h4, 20'h0);
    ic(1'h1, 1'h1);
    ic(1'h1, 1'h0);
    wr(IDX, 64'hF_FFFB, 20'h0);
    ic(1'h1, 1'h1);
    // Unit disabled with every local enable on
    wr(IDX, 64'hF_FFFF, 20'h0);
    for (int k = 0; k < 8; k++)
      for (int o = 0; o < 6; o++)
        ev(k, o, 1'h0);
    // Random writes, masks, reads and events
    repeat (300)
    begin
      wd = {rnd(), rnd()};
      wr(IDX, wd, 20'(rnd() & rnd()));
      rd(IDX);
      wd[31:0] = rnd();
      ev(int'(wd[2:0]), int'(wd[7:4]) % 6, wd[9]);
    end
    end_sim();
  end
endmodule

bind buere_top buere_properties buere_properties_i
(
  .CLOCK                 (CLOCK),
  .RESET                 (RESET),
  .MSR_RD_EN             (MSR_RD_EN),
  .MSR_INDEX             (MSR_INDEX),
  .MSR_RDATA             (MSR_RDATA),
  .MSR_RD_HIT            (MSR_RD_HIT),
  .GLOBAL_BUS_UNIT_ENABLE(GLOBAL_BUS_UNIT_ENABLE),
  .ERR_VALID             (ERR_VALID),
  .ERR_KIND              (ERR_KIND),
  .ERR_OP                (ERR_OP),
  .ICACHE_READERR_EN     (ICACHE_READERR_EN),
  .ICACHE_READERR_VALID  (ICACHE_READERR_VALID),
  .LOG_STROBE            (LOG_STROBE),
  .LOG_KIND              (LOG_KIND),
  .LOG_OP                (LOG_OP),
  .MCE_REQUEST           (MCE_REQUEST),
  .ICACHE_READERR_REPORT (ICACHE_READERR_REPORT)
);

`default_nettype wire
